// >>> logic/frp_pkg.sv
// Purpose: Shared constants for the flash function and read-parameter register block.
// Assumes: Registers are 8 bits wide and are reached by serial commands.
// Notes:   Opcodes for the function register access are free parameters of the top.
package frp_pkg;
   localparam int unsigned REG_W        = 8;
   localparam int unsigned DUMMY_W      = 4;
   localparam int unsigned SYNC_DEPTH   = 3;

   // Function register fields.
   localparam int unsigned FN_RSTDIS    = 0;
   localparam int unsigned FN_TBS       = 1;
   localparam int unsigned FN_PROGRAM_SUSPENDED_FLAG      = 2;
   localparam int unsigned FN_ERASE_SUSPENDED_FLAG      = 3;
   localparam int unsigned FN_IRL_LO    = 4;
   localparam int unsigned FN_IRL_HI    = 7;
   localparam logic [7:0]  FN_OTP_MASK  = 8'hf3;
   localparam logic [7:0]  FN_RESET     = 8'h00;

   // Read-parameter register fields.
   localparam int unsigned RP_BURST_LO  = 0;
   localparam int unsigned RP_BURST_HI  = 1;
   localparam int unsigned RP_WRAP      = 2;
   localparam int unsigned RP_DUMMY_LO  = 3;
   localparam int unsigned RP_DUMMY_HI  = 6;
   localparam int unsigned RP_PINSEL    = 7;
   localparam logic [7:0]  RP_RESET     = 8'h00;

   // Wrap lengths in bytes, indexed by the burst field; WRAP_ARRAY is used when wrap is off.
   localparam logic [6:0]  WRAP_8       = 7'h08;
   localparam logic [6:0]  WRAP_16      = 7'h10;
   localparam logic [6:0]  WRAP_32      = 7'h20;
   localparam logic [6:0]  WRAP_64      = 7'h40;
   localparam logic [6:0]  WRAP_ARRAY   = 7'h00;

   // Serial command opcodes.
   localparam logic [7:0]  OP_SET_RP_NV   = 8'h65;
   localparam logic [7:0]  OP_SET_RP_V    = 8'hc0;
   localparam logic [7:0]  OP_SET_RP_V_WE = 8'h63;
   localparam logic [7:0]  OP_WRITE_EN    = 8'h06;

   typedef enum logic [1:0] {
      FRP_ST_OPC,
      FRP_ST_DATA,
      FRP_ST_READ,
      FRP_ST_SKIP
   } frp_state_t;
endpackage : frp_pkg

// >>> logic/frp_serial_rx.sv
// Purpose: Synchronises the serial pins and assembles command bytes (SPI mode 0).
// Assumes: Serial clock is far slower than clock_i; pins are asynchronous.
// Notes:   A pin change counts only once the second and third stages agree.
module frp_serial_rx
   import frp_pkg::*;
(
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                rst_i,
   // Pins
   input  wire logic                sck_i,
   input  wire logic                cs_n_i,
   input  wire logic                si_i,
   // Byte stream
   output logic                     start_o,
   output logic                     sck_fall_o,
   output logic                     byte_valid_o,
   output logic [frp_pkg::REG_W-1:0] byte_o
);
   import frp_pkg::*;

   logic [SYNC_DEPTH-1:0] sck_s;
   logic [SYNC_DEPTH-1:0] cs_s;
   logic [SYNC_DEPTH-1:0] si_s;
   logic                  sck_f;
   logic                  cs_f;
   logic                  si_f;
   logic [2:0]            bit_cnt;
   logic [REG_W-2:0]      shift;

   always_ff @(posedge clock_i)
   begin
      sck_s <= {sck_s[SYNC_DEPTH-2:0], sck_i};
      cs_s  <= {cs_s[SYNC_DEPTH-2:0], cs_n_i};
      si_s  <= {si_s[SYNC_DEPTH-2:0], si_i};
   end

   // Filtered levels follow only when stages two and three agree.
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         sck_f <= 1'b0;
         cs_f  <= 1'b1;
         si_f  <= 1'b0;
      end
      else
      begin
         if (sck_s[1] == sck_s[2]) sck_f <= sck_s[2];
         if (cs_s[1] == cs_s[2]) cs_f <= cs_s[2];
         if (si_s[1] == si_s[2]) si_f <= si_s[2];
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         start_o      <= 1'b0;
         sck_fall_o   <= 1'b0;
         byte_valid_o <= 1'b0;
         byte_o       <= 8'h00;
         bit_cnt      <= 3'h0;
         shift        <= 7'h00;
      end
      else
      begin
         start_o      <= cs_f && (cs_s[1] == cs_s[2]) && !cs_s[2];
         sck_fall_o   <= !cs_f && sck_f && (sck_s[1] == sck_s[2]) && !sck_s[2];
         byte_valid_o <= 1'b0;
         if (cs_f)
            bit_cnt <= 3'h0;
         else if (!sck_f && (sck_s[1] == sck_s[2]) && sck_s[2])
         begin
            bit_cnt <= bit_cnt + 3'h1;
            shift   <= {shift[REG_W-3:0], si_f};
            if (bit_cnt == 3'h7)
            begin
               byte_valid_o <= 1'b1;
               byte_o       <= {shift, si_f};
            end
         end
      end
   end
endmodule : frp_serial_rx

// >>> logic/frp_regs.sv
// Purpose: Function register and read-parameter register of a serial flash.
// Assumes: Suspend, resume and power-up events come from logic on clock_i.
// Notes:   Registers are reached only through serial commands on the pins.
// Behaviour
// - Bit zero reports dedicated reset disabled; settable only while it reads zero.
// - One-time-programmable function bits never return to zero once set.
// - Bit zero default follows package; setting it moves reset to shared pin.
// - Bit one places protection at top or bottom; bottom is permanent.
// - Program suspended flag sets on suspend during program, clears on resume.
// - Erase suspended flag sets on suspend during erase, clears on resume.
// - Bits four to seven lock information rows zero to three permanently.
// - Power-up loads the volatile read-parameter copy from the non-volatile one.
// - Pin select chooses pause or reset role only without quad or four-wire.
// - With a dedicated reset pin, shared pin stays pause in single-wire mode until bit zero is set.
// - Dummy field bits six to three give one to fifteen dummy cycles.
// - Burst field encodes wrap length of 8, 16, 32 or 64 bytes.
// - Wrap enable zero wraps at array end; one wraps at burst length.
// - Opcode 65h writes non-volatile copy; C0h or 63h writes volatile copy.
// - Opcode C0h needs no preceding write-enable command.
// - Quad enable turns pause/reset and write-protect pins into data lines.
module frp_regs
   import frp_pkg::*;
#(
   parameter logic                 HAS_DEDICATED_RESET = 1'b1,
   parameter logic                 RSTDIS_DEFAULT      = 1'b0,
   parameter logic [DUMMY_W-1:0]   DUMMY_DEFAULT       = 4'h8,
   parameter logic [REG_W-1:0]     OP_WRITE_FN         = 8'h42,
   parameter logic [REG_W-1:0]     OP_READ_FN          = 8'h48,
   parameter logic [REG_W-1:0]     OP_READ_RP          = 8'h61
)
(
   // Clock and reset
   input  wire logic                        clock_i,
   input  wire logic                        rst_i,
   // Serial pins
   input  wire logic                        sck_i,
   input  wire logic                        cs_n_i,
   input  wire logic                        si_i,
   output logic                             so_o,
   output logic                             so_oe_o,
   // Device events
   input  wire logic                        power_up_i,
   input  wire logic                        prog_suspend_i,
   input  wire logic                        prog_resume_i,
   input  wire logic                        erase_suspend_i,
   input  wire logic                        erase_resume_i,
   // Mode inputs
   input  wire logic                        quad_io_enable_i,
   input  wire logic                        four_wire_command_mode_i,
   // Function register outputs
   output logic                             dedicated_reset_enabled_o,
   output logic                             bottom_protect_o,
   output logic                             program_suspended_flag_o,
   output logic                             erase_suspended_flag_o,
   output logic [3:0]                       info_row_lock_o,
   // Pin roles
   output logic                             shared_pin_reset_role_o,
   output logic                             shared_pin_data_o,
   output logic                             wp_pin_data_o,
   // Read configuration
   output logic [frp_pkg::DUMMY_W-1:0]      dummy_cycles_o,
   output logic                             wrap_enable_o,
   output logic [6:0]                       wrap_bytes_o
);
   import frp_pkg::*;

   logic                 start;
   logic                 sck_fall;
   logic                 byte_valid;
   logic [REG_W-1:0]     rx_byte;
   frp_state_t           state;
   logic [REG_W-1:0]     cmd;
   logic                 wel;
   logic                 rst_default_done;
   logic [REG_W-1:0]     fn_reg;
   logic [REG_W-1:0]     rp_nv;
   logic [REG_W-1:0]     rp_vol;
   logic [REG_W-1:0]     out_shift;
   logic                 wr_fn;
   logic                 wr_nv;
   logic                 wr_vol;
   logic [REG_W-1:0]     next_fn;
   logic [SYNC_DEPTH-1:0] cs_pipe;
   logic                 cs_idle;

   function automatic logic [6:0] wrap_len(input logic [1:0] sel);
      case (sel)
         2'h0:    wrap_len = WRAP_8;
         2'h1:    wrap_len = WRAP_16;
         2'h2:    wrap_len = WRAP_32;
         default: wrap_len = WRAP_64;
      endcase
   endfunction : wrap_len

   frp_serial_rx frp_serial_rx_inst (
      .clock_i      (clock_i),
      .rst_i        (rst_i),
      .sck_i        (sck_i),
      .cs_n_i       (cs_n_i),
      .si_i         (si_i),
      .start_o      (start),
      .sck_fall_o   (sck_fall),
      .byte_valid_o (byte_valid),
      .byte_o       (rx_byte)
   );

   // Write strobes fire on the data byte that follows the opcode.
   assign wr_fn  = byte_valid && (state == FRP_ST_DATA) && (cmd == OP_WRITE_FN);
   assign wr_nv  = byte_valid && (state == FRP_ST_DATA) && (cmd == OP_SET_RP_NV);
   assign wr_vol = byte_valid && (state == FRP_ST_DATA) &&
                   ((cmd == OP_SET_RP_V) || (cmd == OP_SET_RP_V_WE));

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state <= FRP_ST_SKIP;
         cmd   <= 8'h00;
         wel   <= 1'b0;
      end
      else if (start)
         state <= FRP_ST_OPC;
      else if (byte_valid)
      begin
         case (state)
            FRP_ST_OPC:
            begin
               cmd <= rx_byte;
               if (rx_byte == OP_WRITE_EN)
               begin
                  wel   <= 1'b1;
                  state <= FRP_ST_SKIP;
               end
               else if ((rx_byte == OP_SET_RP_V) ||
                        (wel && ((rx_byte == OP_SET_RP_NV) ||
                                 (rx_byte == OP_SET_RP_V_WE) ||
                                 (rx_byte == OP_WRITE_FN))))
                  state <= FRP_ST_DATA;
               else if ((rx_byte == OP_READ_FN) || (rx_byte == OP_READ_RP))
                  state <= FRP_ST_READ;
               else
                  state <= FRP_ST_SKIP;
            end
            FRP_ST_DATA:
            begin
               // Write-enable is consumed by any completed write.
               wel   <= 1'b0;
               state <= FRP_ST_SKIP;
            end
            FRP_ST_READ: state <= FRP_ST_READ;
            FRP_ST_SKIP: state <= FRP_ST_SKIP;
            default:     state <= FRP_ST_SKIP;
         endcase
      end
   end

   // Only one-time-programmable bits can be raised; suspend flags ignore writes.
   always_comb
   begin
      next_fn = fn_reg | (rx_byte & FN_OTP_MASK);
      next_fn[FN_PROGRAM_SUSPENDED_FLAG] = (fn_reg[FN_PROGRAM_SUSPENDED_FLAG] & ~prog_resume_i) | prog_suspend_i;
      next_fn[FN_ERASE_SUSPENDED_FLAG] = (fn_reg[FN_ERASE_SUSPENDED_FLAG] & ~erase_resume_i) | erase_suspend_i;
      if (!wr_fn)
         next_fn[REG_W-1:0] = {fn_reg[FN_IRL_HI:FN_IRL_LO], next_fn[FN_ERASE_SUSPENDED_FLAG:FN_PROGRAM_SUSPENDED_FLAG],
                               fn_reg[FN_TBS:FN_RSTDIS]};
   end

   // The package default of bit zero is applied on the first cycle after reset.
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         fn_reg           <= FN_RESET;
         rst_default_done <= 1'b0;
      end
      else
      begin
         rst_default_done <= 1'b1;
         fn_reg           <= next_fn;
         if (!rst_default_done)
            fn_reg[FN_RSTDIS] <= RSTDIS_DEFAULT;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         rp_nv  <= RP_RESET;
         rp_vol <= RP_RESET;
      end
      else
      begin
         if (wr_nv)
            rp_nv <= rx_byte;
         if (power_up_i)
            rp_vol <= rp_nv;
         else if (wr_vol)
            rp_vol <= rx_byte;
      end
   end

   // The select pin gets its own three stages, so the output enable never sees a raw
   // asynchronous level and cannot go metastable when the host releases the bus.
   always_ff @(posedge clock_i)
   begin
      cs_pipe <= {cs_pipe[SYNC_DEPTH-2:0], cs_n_i};
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         cs_idle <= 1'b1;
      else if (cs_pipe[1] == cs_pipe[2])
         cs_idle <= cs_pipe[2];
   end

   // Read data leaves on falling serial edges, most significant bit first.
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         out_shift <= 8'h00;
         so_o      <= 1'b0;
         so_oe_o   <= 1'b0;
      end
      else
      begin
         if (byte_valid && (state == FRP_ST_OPC))
            out_shift <= (rx_byte == OP_READ_FN) ? fn_reg : rp_vol;
         else if (sck_fall && (state == FRP_ST_READ))
         begin
            so_o      <= out_shift[REG_W-1];
            out_shift <= {out_shift[REG_W-2:0], out_shift[REG_W-1]};
         end
         so_oe_o <= (state == FRP_ST_READ) && !cs_idle;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         dedicated_reset_enabled_o <= 1'b1;
         bottom_protect_o          <= 1'b0;
         program_suspended_flag_o  <= 1'b0;
         erase_suspended_flag_o    <= 1'b0;
         info_row_lock_o           <= 4'h0;
      end
      else
      begin
         dedicated_reset_enabled_o <= HAS_DEDICATED_RESET && !fn_reg[FN_RSTDIS];
         bottom_protect_o          <= fn_reg[FN_TBS];
         program_suspended_flag_o  <= fn_reg[FN_PROGRAM_SUSPENDED_FLAG];
         erase_suspended_flag_o    <= fn_reg[FN_ERASE_SUSPENDED_FLAG];
         info_row_lock_o           <= fn_reg[FN_IRL_HI:FN_IRL_LO];
      end
   end

   // A dedicated-reset part keeps the shared pin as pause until reset is moved to it.
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         shared_pin_reset_role_o <= 1'b0;
         shared_pin_data_o       <= 1'b0;
         wp_pin_data_o           <= 1'b0;
         dummy_cycles_o          <= 4'h0;
         wrap_enable_o           <= 1'b0;
         wrap_bytes_o            <= WRAP_ARRAY;
      end
      else
      begin
         shared_pin_reset_role_o <= !quad_io_enable_i && !four_wire_command_mode_i &&
                                    rp_vol[RP_PINSEL] &&
                                    (!HAS_DEDICATED_RESET || fn_reg[FN_RSTDIS]);
         shared_pin_data_o <= quad_io_enable_i || four_wire_command_mode_i;
         wp_pin_data_o     <= quad_io_enable_i || four_wire_command_mode_i;
         dummy_cycles_o    <= (rp_vol[RP_DUMMY_HI:RP_DUMMY_LO] == 4'h0) ? DUMMY_DEFAULT
                              : rp_vol[RP_DUMMY_HI:RP_DUMMY_LO];
         wrap_enable_o     <= rp_vol[RP_WRAP];
         wrap_bytes_o      <= rp_vol[RP_WRAP] ? wrap_len(rp_vol[RP_BURST_HI:RP_BURST_LO])
                              : WRAP_ARRAY;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   otp_bits_sticky_a: assert property (
      rst_default_done |-> ((($past(fn_reg) & FN_OTP_MASK) & ~fn_reg) == 8'h00))
      else $error("one-time bit cleared");
   rstdis_set_a: assert property (
      (wr_fn && rx_byte[FN_RSTDIS] && rst_default_done) |-> ##2
      !dedicated_reset_enabled_o)
      else $error("reset disable bit not set by write");
   prog_flag_set_a: assert property (
      prog_suspend_i |-> ##2 program_suspended_flag_o)
      else $error("program suspended flag not raised");
   erase_flag_clear_a: assert property (
      (erase_resume_i && !erase_suspend_i) |-> ##2 !erase_suspended_flag_o)
      else $error("erase suspended flag not cleared");
   flags_write_ignored_a: assert property (
      (wr_fn && !prog_suspend_i && !prog_resume_i && !erase_suspend_i && !erase_resume_i)
      |=> (fn_reg[FN_ERASE_SUSPENDED_FLAG:FN_PROGRAM_SUSPENDED_FLAG] == $past(fn_reg[FN_ERASE_SUSPENDED_FLAG:FN_PROGRAM_SUSPENDED_FLAG])))
      else $error("suspend flags changed by write");
   powerup_load_a: assert property (
      power_up_i |=> (rp_vol == $past(rp_nv)))
      else $error("volatile copy not loaded at power-up");
   nv_write_only_a: assert property (
      (wr_nv && !power_up_i) |=> ($stable(rp_vol) && (rp_nv == $past(rx_byte))))
      else $error("wrong copy updated by non-volatile write");
   quad_pin_role_a: assert property (
      (quad_io_enable_i || four_wire_command_mode_i) |=>
      (!shared_pin_reset_role_o && shared_pin_data_o && wp_pin_data_o))
      else $error("pin role wrong in quad mode");
   dummy_default_a: assert property (
      (rp_vol[RP_DUMMY_HI:RP_DUMMY_LO] == 4'h0) |=> (dummy_cycles_o == DUMMY_DEFAULT))
      else $error("dummy default not applied");
   wrap_array_a: assert property (
      !rp_vol[RP_WRAP] |=> (wrap_bytes_o == WRAP_ARRAY))
      else $error("wrap length used while wrap disabled");
endmodule : frp_regs

// >>> tb/frp_host.sv
// Purpose: Host serial controller model that drives the register block pins.
// Assumes: Mode 0 frames, opcode then at most one byte, most significant bit first.
// Notes:   The sck half period is counted in clock_i cycles and may be raised.
module frp_host
(
   // Clock
   input  wire logic clock_i,
   // Serial pins
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o,
   input  wire logic so_i
);
   timeunit 1ns;
   timeprecision 1ps;

   int half = 6;

   initial
   begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask : wait_cyc

   // Read data is taken late in the high phase, well clear of the lagging so_i update.
   task automatic frame(input logic [7:0] opc, input logic [7:0] dat, input int nb,
                        output logic [7:0] rd);
      logic [15:0] sh;
      sh = {opc, dat};
      rd = 8'h00;
      @(posedge clock_i);
      cs_n_o <= 1'b0;
      for (int i = 15; i >= 16 - 8 * nb; i--)
      begin
         si_o <= sh[i];
         wait_cyc(half);
         sck_o <= 1'b1;
         wait_cyc(half);
         if (i < 8)
            rd = {rd[6:0], so_i};
         sck_o <= 1'b0;
      end
      wait_cyc(half);
      cs_n_o <= 1'b1;
      // Released data line shows the inverse of its last bit, never a stale copy.
      si_o <= ~sh[16 - 8 * nb];
      wait_cyc(4 * half);
   endtask : frame
endmodule : frp_host

// >>> tb/frp_regs_bench.sv
// Purpose: Self-checking bench for the function and read-parameter registers.
// Assumes: Default strap parameters: dedicated reset pin, bit zero clear.
// Notes:   All register traffic goes through the host model frames.
module frp_regs_bench
   import frp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] WR_FN = 8'h42;
   localparam logic [7:0] RD_FN = 8'h48;
   localparam logic [7:0] RD_RP = 8'h61;

   logic       clock_i = 1'b0;
   logic       rst_i   = 1'b1;
   logic [4:0] ev      = 5'h00;
   logic       quad    = 1'b0;
   logic       four    = 1'b0;
   logic       sck, cs_n, si, so, so_oe, rst_en, bottom, p_flag, e_flag;
   logic       role, sh_data, wp_data, wrap_en;
   logic [3:0] locks, dummy;
   logic [6:0] wrap_b;
   logic [7:0] rd;
   int         failures = 0;
   int         checks   = 0;

   always #2 clock_i = ~clock_i;

   frp_regs #(.OP_WRITE_FN(WR_FN), .OP_READ_FN(RD_FN), .OP_READ_RP(RD_RP)) frp_regs_inst (
      .clock_i(clock_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
      .so_o(so), .so_oe_o(so_oe), .power_up_i(ev[0]), .prog_suspend_i(ev[1]),
      .prog_resume_i(ev[2]), .erase_suspend_i(ev[3]), .erase_resume_i(ev[4]),
      .quad_io_enable_i(quad), .four_wire_command_mode_i(four),
      .dedicated_reset_enabled_o(rst_en), .bottom_protect_o(bottom),
      .program_suspended_flag_o(p_flag), .erase_suspended_flag_o(e_flag),
      .info_row_lock_o(locks), .shared_pin_reset_role_o(role),
      .shared_pin_data_o(sh_data), .wp_pin_data_o(wp_data), .dummy_cycles_o(dummy),
      .wrap_enable_o(wrap_en), .wrap_bytes_o(wrap_b));

   frp_host frp_host_inst (.clock_i(clock_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si),
                           .so_i(so));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   task automatic pulse(input int b);
      @(posedge clock_i);
      ev[b] <= 1'b1;
      @(posedge clock_i);
      ev <= 5'h00;
      repeat (3) @(posedge clock_i);
   endtask : pulse

   task automatic modes(input logic q, input logic f);
      @(posedge clock_i);
      quad <= q;
      four <= f;
      repeat (3) @(posedge clock_i);
   endtask : modes

   // Write enable goes in a frame of its own, as the device demands.
   task automatic wr(input logic [7:0] opc, input logic [7:0] dat, input logic we);
      if (we)
         frp_host_inst.frame(OP_WRITE_EN, 8'h00, 1, rd);
      frp_host_inst.frame(opc, dat, 2, rd);
   endtask : wr

   task automatic rdreg(input logic [7:0] opc);
      frp_host_inst.frame(opc, 8'h00, 2, rd);
   endtask : rdreg

   task automatic t_reset;
      chk(8'(rst_en), 8'h01);
      chk(8'({bottom, p_flag, e_flag, locks}), 8'h00);
      chk(8'(dummy), 8'h08);
      chk(8'({wrap_en, wrap_b}), 8'h00);
      rdreg(RD_FN);
      chk(rd, 8'h00);
      chk(8'(so_oe), 8'h00);
      rdreg(RD_RP);
      chk(rd, 8'h00);
   endtask : t_reset

   task automatic t_vol;
      logic [3:0] dc [4] = '{4'h1, 4'hf, 4'h6, 4'h9};
      logic [6:0] wb [4] = '{7'h08, 7'h10, 7'h20, 7'h40};
      for (int b = 0; b < 4; b++)
      begin
         wr(OP_SET_RP_V, {1'b0, dc[b], 1'b1, 2'(b)}, 1'b0);
         chk(8'(dummy), 8'(dc[b]));
         chk(8'(wrap_b), 8'(wb[b]));
         rdreg(RD_RP);
         chk(rd, {1'b0, dc[b], 1'b1, 2'(b)});
      end
      wr(OP_SET_RP_V, 8'h1b, 1'b0);
      chk(8'({wrap_en, wrap_b}), 8'h00);
   endtask : t_vol

   task automatic t_nv;
      wr(OP_SET_RP_V_WE, 8'h2c, 1'b0);
      rdreg(RD_RP);
      chk(rd, 8'h1b);
      wr(OP_SET_RP_V_WE, 8'h2c, 1'b1);
      rdreg(RD_RP);
      chk(rd, 8'h2c);
      wr(OP_SET_RP_NV, 8'h80, 1'b0);
      pulse(0);
      rdreg(RD_RP);
      chk(rd, 8'h00);
      wr(OP_SET_RP_NV, 8'h80, 1'b1);
      rdreg(RD_RP);
      chk(rd, 8'h00);
      pulse(0);
      rdreg(RD_RP);
      chk(rd, 8'h80);
   endtask : t_nv

   task automatic t_fn;
      chk(8'(role), 8'h00);
      wr(WR_FN, 8'hff, 1'b1);
      rdreg(RD_FN);
      chk(rd, 8'hf3);
      chk(8'(rst_en), 8'h00);
      chk(8'({bottom, locks}), 8'h1f);
      chk(8'(role), 8'h01);
      wr(WR_FN, 8'h00, 1'b1);
      rdreg(RD_FN);
      chk(rd, 8'hf3);
      modes(1'b1, 1'b0);
      chk(8'({role, sh_data, wp_data}), 8'h03);
      modes(1'b0, 1'b1);
      chk(8'({role, sh_data, wp_data}), 8'h03);
      modes(1'b0, 1'b0);
      chk(8'({role, sh_data, wp_data}), 8'h04);
   endtask : t_fn

   task automatic t_sus;
      pulse(1);
      chk(8'({p_flag, e_flag}), 8'h02);
      rdreg(RD_FN);
      chk(rd, 8'hf7);
      pulse(2);
      chk(8'({p_flag, e_flag}), 8'h00);
      pulse(3);
      chk(8'({p_flag, e_flag}), 8'h01);
      wr(WR_FN, 8'h00, 1'b1);
      rdreg(RD_FN);
      chk(rd, 8'hfb);
      pulse(4);
      chk(8'({p_flag, e_flag}), 8'h00);
   endtask : t_sus

   initial
   begin
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clock_i);
      t_reset;
      t_vol;
      t_nv;
      t_fn;
      t_sus;
      results;
   end

   // Thirty-two frames in all; this span leaves a wide margin.
   initial
   begin
      #200000;
      failures++;
      results;
   end
endmodule : frp_regs_bench
